// ===== hdl/igb_pkg.sv
/*
 * igb_pkg: shared constants, mode encoding and the register map of the
 * input gearbox.
 * Assumes: compiled before every other file of the gearbox.
 */
package igb_pkg;

    // gearbox arrangements
    typedef enum logic [1:0] {
        IGB_MODE_SEVEN = 2'b00,   // 1:7 video deserializer
        IGB_MODE_EIGHT = 2'b01,   // one 1:8 ddr gearbox
        IGB_MODE_DUAL  = 2'b10,   // two 1:4 ddr gearboxes
        IGB_MODE_SPARE = 2'b11    // behaves as the 1:8 gearbox
    } igb_mode_type;

    // lanes: index 1 is io_logic_a, index 0 is io_logic_c
    localparam int IGB_LANES  = 2;
    localparam int IGB_LANE_A = 1;
    localparam int IGB_LANE_C = 0;

    // datapath sizes
    localparam int         IGB_WORD_W      = 8;
    localparam int         IGB_HIST_W      = 16;
    localparam logic [3:0] IGB_WIDTH_SEVEN = 4'h7;
    localparam logic [3:0] IGB_WIDTH_EIGHT = 4'h8;
    localparam logic [3:0] IGB_WIDTH_FOUR  = 4'h4;
    localparam logic [3:0] IGB_PAIR_BITS   = 4'h2;   // bits taken per fast cycle

    // register map, byte addresses
    localparam int         IGB_ADDR_W     = 4;
    localparam logic [3:0] IGB_REG_CTRL   = 4'h0;
    localparam logic [3:0] IGB_REG_STATUS = 4'h4;
    localparam logic [3:0] IGB_REG_WCOUNT = 4'h8;

    // field positions
    localparam int IGB_CTRL_MODE_LSB   = 0;
    localparam int IGB_STAT_POS_LSB    = 0;
    localparam int IGB_STAT_POS_STRIDE = 4;
    localparam int IGB_STAT_MODE_LSB   = 8;
    localparam int IGB_STAT_DROP_LSB   = 16;
    localparam int IGB_WCNT_STRIDE     = 16;

    // values after reset
    localparam igb_mode_type IGB_CTRL_MODE_RST = IGB_MODE_EIGHT;
    localparam logic [2:0]   IGB_POS_RST       = 3'h0;
    localparam logic [15:0]  IGB_WCNT_RST      = 16'h0000;

    // spacing between two accepted alignment requests
    localparam int         IGB_SYS_CLK_MHZ    = 200;
    localparam int         IGB_ALIGN_GUARD_NS = 200;
    localparam int         IGB_ALIGN_GUARD_CYC =
        (IGB_ALIGN_GUARD_NS * IGB_SYS_CLK_MHZ + 999) / 1000;
    localparam logic [5:0] IGB_ALIGN_GUARD_LOAD = 6'(IGB_ALIGN_GUARD_CYC);

    // word width that a lane runs at in a given arrangement
    function automatic logic [3:0] igb_lane_width(igb_mode_type mode, int lane);
        logic [3:0] w;
        w = IGB_WIDTH_EIGHT;
        if (lane == IGB_LANE_C || mode == IGB_MODE_DUAL) begin
            w = IGB_WIDTH_FOUR;
        end else if (mode == IGB_MODE_SEVEN) begin
            w = IGB_WIDTH_SEVEN;
        end
        return w;
    endfunction : igb_lane_width

endpackage : igb_pkg

// ===== hdl/igb_lane.sv
/*
 * igb_lane: capture and alignment stages of one gearbox lane, all on the
 * fast edge clock.
 * Assumes: fast_rst is asserted asynchronously and released on the fast
 * clock; word_width is steady between word changes; slip_tgl toggles once
 * per alignment request and comes from another clock.
 */
`timescale 1ns/10ps
module igb_lane
    import igb_pkg::*;
(
    input  wire logic                  fast_edge_clk,
    input  wire logic                  fast_rst,
    input  wire logic                  serial_in,
    input  wire logic [3:0]            word_width,
    input  wire logic                  slip_tgl,
    output logic      [IGB_WORD_W-1:0] word_r,
    output logic                       word_tgl_r
);

    logic                  rise_r;
    logic                  fall_r;
    logic [IGB_HIST_W-1:0] hist_r;
    logic [IGB_HIST_W-1:0] hist_nxt;
    logic [3:0]            cnt_r;
    logic [3:0]            cnt_nxt;
    logic [3:0]            cnt_sum;
    logic [3:0]            shamt;
    logic [IGB_HIST_W-1:0] shifted;
    logic                  update_stb;
    logic                  align_choice;
    logic [IGB_WORD_W-1:0] word_nxt;
    logic                  word_tgl_nxt;
    logic                  slip_s1_r;
    logic                  slip_s2_r;
    logic                  slip_s3_r;

    // first stage: sample on the rising edge
    always_ff @(posedge fast_edge_clk or posedge fast_rst) begin
        if (fast_rst) begin
            rise_r <= 1'b0;
        end else begin
            rise_r <= serial_in;
        end
    end

    // first stage: sample on the falling edge
    always_ff @(negedge fast_edge_clk or posedge fast_rst) begin
        if (fast_rst) begin
            fall_r <= 1'b0;
        end else begin
            fall_r <= serial_in;
        end
    end

    // slip request toggle synchroniser, edge seen between stages two and three
    assign align_choice = slip_s2_r ^ slip_s3_r;

    // second stage: bit history, boundary counter and word extraction
    always_comb begin
        hist_nxt     = {hist_r[IGB_HIST_W-3:0], rise_r, fall_r};   // older bit first
        cnt_sum      = cnt_r + IGB_PAIR_BITS - {3'h0, align_choice};
        update_stb   = (cnt_sum >= word_width);
        shamt        = cnt_sum - word_width;
        shifted      = hist_nxt >> shamt;
        cnt_nxt      = update_stb ? shamt : cnt_sum;
        word_nxt     = word_r;
        if (update_stb) begin
            word_nxt = shifted[IGB_WORD_W-1:0] & (8'hFF >> (4'h8 - word_width));
        end
        word_tgl_nxt = word_tgl_r ^ update_stb;
    end

    // second stage registers
    always_ff @(posedge fast_edge_clk or posedge fast_rst) begin
        if (fast_rst) begin
            hist_r     <= 16'h0000;
            cnt_r      <= 4'h0;
            word_r     <= 8'h00;
            word_tgl_r <= 1'b0;
            slip_s1_r  <= 1'b0;
            slip_s2_r  <= 1'b0;
            slip_s3_r  <= 1'b0;
        end else begin
            hist_r     <= hist_nxt;
            cnt_r      <= cnt_nxt;
            word_r     <= word_nxt;
            word_tgl_r <= word_tgl_nxt;
            slip_s1_r  <= slip_tgl;
            slip_s2_r  <= slip_s1_r;
            slip_s3_r  <= slip_s2_r;
        end
    end

endmodule : igb_lane

// ===== hdl/igb_gearbox.sv
/*
 * igb_gearbox: input gearbox of one bottom-edge io_cell_group. Serial data
 * is captured and aligned on the fast edge clock and handed to the core as
 * parallel words on clk, with a small register port for set-up and status.
 * Assumes: serial inputs already pass the programmable input delay; the
 * core pulses word_align_req on clk; the fast clock is much slower than clk.
 */
// What this block does
// - one input gearbox per cell group, words of up to eight bits
// - runs as 1:7 deserializer, one 1:8 gearbox, or two 1:4 gearboxes
// - word on bits 6..0 in seven-bit mode, bits 7..0 in eight-bit mode
// - dual mode: lane of io_logic_a drives word bits 7..4
// - dual mode: lane of io_logic_c drives word bits 3..0
// - datapath is three register stages: capture, alignment, core transfer
// - capture samples serial input on both edges of the fast edge clock
// - alignment picks word boundary from update strobe and align choice
// - third stage registers aligned word on the system clock for the core
`timescale 1ns/10ps
module igb_gearbox
    import igb_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  fast_edge_clk,
    input  wire logic                  serial_in_a,
    input  wire logic                  serial_in_c,
    input  wire logic [IGB_LANES-1:0]  word_align_req,
    input  wire logic [IGB_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata_r,
    output logic      [IGB_WORD_W-1:0] par_word_r,
    output logic      [IGB_LANES-1:0]  word_valid_r
);

    // fast domain reset and mode copy
    logic                  frst_s1_r;
    logic                  frst_s2_r;
    logic                  fast_rst;
    logic [1:0]            mode_s1_r;
    logic [1:0]            mode_s2_r;

    // control register
    igb_mode_type          ctrl_mode_r;
    igb_mode_type          ctrl_mode_nxt;
    logic                  ctrl_wr;
    logic                  stat_wr;
    logic                  wcnt_wr;

    // per lane signals
    logic [IGB_LANES-1:0]  serial_vec;
    logic [IGB_LANES-1:0]  lane_cap;
    logic [IGB_LANES-1:0]  lane_drop;
    logic [IGB_WORD_W-1:0] lane_word [IGB_LANES];
    logic [2:0]            lane_pos  [IGB_LANES];
    logic [15:0]           lane_wcnt [IGB_LANES];

    // third stage and read data
    logic [IGB_WORD_W-1:0] par_word_nxt;
    logic [IGB_LANES-1:0]  word_valid_nxt;
    logic [31:0]           reg_rdata_nxt;
    logic [31:0]           status_word;
    logic [31:0]           wcount_word;

    assign serial_vec = {serial_in_a, serial_in_c};
    assign fast_rst   = frst_s2_r;
    assign ctrl_wr    = reg_wr && (reg_addr == IGB_REG_CTRL);
    assign stat_wr    = reg_wr && (reg_addr == IGB_REG_STATUS);
    assign wcnt_wr    = reg_wr && (reg_addr == IGB_REG_WCOUNT);

    // fast domain reset: asserted at once, released on the fast clock
    always_ff @(posedge fast_edge_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frst_s1_r <= 1'b1;
            frst_s2_r <= 1'b1;
        end else begin
            frst_s1_r <= 1'b0;
            frst_s2_r <= frst_s1_r;
        end
    end

    // mode is a slow level, carried into the fast domain by two flops
    always_ff @(posedge fast_edge_clk or posedge fast_rst) begin
        if (fast_rst) begin
            mode_s1_r <= IGB_CTRL_MODE_RST;
            mode_s2_r <= IGB_CTRL_MODE_RST;
        end else begin
            mode_s1_r <= ctrl_mode_r;
            mode_s2_r <= mode_s1_r;
        end
    end

    // control register next value
    always_comb begin
        ctrl_mode_nxt = ctrl_mode_r;
        if (ctrl_wr) begin
            ctrl_mode_nxt = igb_mode_type'(reg_wdata[IGB_CTRL_MODE_LSB +: 2]);
        end
    end

    // control register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_mode_r <= IGB_CTRL_MODE_RST;
        end else begin
            ctrl_mode_r <= ctrl_mode_nxt;
        end
    end

    // one gearbox lane per cell half, with its clk side bookkeeping
    genvar gl;
    generate
        for (gl = 0; gl < IGB_LANES; gl++) begin : gen_lane
            logic       lane_active;
            logic [3:0] width_sys;
            logic [3:0] width_fast;
            logic       req_hit;
            logic       accept;
            logic       req_tgl_r;
            logic       req_tgl_nxt;
            logic [5:0] guard_r;
            logic [5:0] guard_nxt;
            logic       drop_r;
            logic       drop_nxt;
            logic [2:0] pos_r;
            logic [2:0] pos_nxt;
            logic       wt_tgl;
            logic       wt_s1_r;
            logic       wt_s2_r;
            logic       wt_s3_r;
            logic [15:0] wcnt_r;
            logic [15:0] wcnt_nxt;

            assign lane_active = (gl == IGB_LANE_A) || (ctrl_mode_r == IGB_MODE_DUAL);
            assign width_sys   = igb_lane_width(ctrl_mode_r, gl);
            assign width_fast  = igb_lane_width(igb_mode_type'(mode_s2_r), gl);
            assign req_hit     = word_align_req[gl] && lane_active;
            assign accept      = req_hit && (guard_r == 6'h00);
            assign lane_cap[gl]  = wt_s2_r ^ wt_s3_r;
            assign lane_drop[gl] = drop_r;
            assign lane_pos[gl]  = pos_r;
            assign lane_wcnt[gl] = wcnt_r;

            // capture and alignment stages on the fast clock
            igb_lane u_lane (
                .fast_edge_clk (fast_edge_clk),
                .fast_rst      (fast_rst),
                .serial_in     (serial_vec[gl]),
                .word_width    (width_fast),
                .slip_tgl      (req_tgl_r),
                .word_r        (lane_word[gl]),
                .word_tgl_r    (wt_tgl)
            );

            // request toggle, guard spacing, drop flag, position and word count
            always_comb begin
                req_tgl_nxt = req_tgl_r ^ accept;
                guard_nxt   = guard_r;
                if (accept) begin
                    guard_nxt = IGB_ALIGN_GUARD_LOAD;
                end else if (guard_r != 6'h00) begin
                    guard_nxt = guard_r - 6'h01;
                end
                // a refused request beats a clear in the same cycle
                drop_nxt = drop_r;
                if (stat_wr && reg_wdata[IGB_STAT_DROP_LSB + gl]) begin
                    drop_nxt = 1'b0;
                end
                if (req_hit && !accept) begin
                    drop_nxt = 1'b1;
                end
                pos_nxt = pos_r;
                if (ctrl_wr) begin
                    pos_nxt = IGB_POS_RST;
                end else if (accept) begin
                    pos_nxt = ({1'b0, pos_r} == width_sys - 4'h1) ? IGB_POS_RST
                                                                  : pos_r + 3'h1;
                end
                wcnt_nxt = wcnt_r;
                if (wcnt_wr) begin
                    wcnt_nxt = IGB_WCNT_RST;
                end else if (lane_cap[gl] && lane_active) begin
                    wcnt_nxt = wcnt_r + 16'h0001;
                end
            end

            // clk side lane registers, word toggle synchroniser among them
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    req_tgl_r <= 1'b0;
                    guard_r   <= 6'h00;
                    drop_r    <= 1'b0;
                    pos_r     <= IGB_POS_RST;
                    wt_s1_r   <= 1'b0;
                    wt_s2_r   <= 1'b0;
                    wt_s3_r   <= 1'b0;
                    wcnt_r    <= IGB_WCNT_RST;
                end else begin
                    req_tgl_r <= req_tgl_nxt;
                    guard_r   <= guard_nxt;
                    drop_r    <= drop_nxt;
                    pos_r     <= pos_nxt;
                    wt_s1_r   <= wt_tgl;
                    wt_s2_r   <= wt_s1_r;
                    wt_s3_r   <= wt_s2_r;
                    wcnt_r    <= wcnt_nxt;
                end
            end
        end
    endgenerate

    // third stage: place each lane word in its bits of the core word
    always_comb begin
        par_word_nxt   = par_word_r;
        word_valid_nxt = '0;
        case (ctrl_mode_r)
            IGB_MODE_SEVEN: begin
                if (lane_cap[IGB_LANE_A]) begin
                    par_word_nxt = {1'b0, lane_word[IGB_LANE_A][6:0]};
                    word_valid_nxt[IGB_LANE_A] = 1'b1;
                end
            end
            IGB_MODE_DUAL: begin
                if (lane_cap[IGB_LANE_A]) begin
                    par_word_nxt[7:4] = lane_word[IGB_LANE_A][3:0];
                    word_valid_nxt[IGB_LANE_A] = 1'b1;
                end
                if (lane_cap[IGB_LANE_C]) begin
                    par_word_nxt[3:0] = lane_word[IGB_LANE_C][3:0];
                    word_valid_nxt[IGB_LANE_C] = 1'b1;
                end
            end
            default: begin
                if (lane_cap[IGB_LANE_A]) begin
                    par_word_nxt = lane_word[IGB_LANE_A];
                    word_valid_nxt[IGB_LANE_A] = 1'b1;
                end
            end
        endcase
    end

    // third stage registers on the system clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            par_word_r   <= 8'h00;
            word_valid_r <= 2'h0;
        end else begin
            par_word_r   <= par_word_nxt;
            word_valid_r <= word_valid_nxt;
        end
    end

    // read data: status fields gathered per lane
    always_comb begin
        status_word = 32'h0000_0000;
        wcount_word = 32'h0000_0000;
        for (int i = 0; i < IGB_LANES; i++) begin
            status_word[IGB_STAT_POS_LSB + i * IGB_STAT_POS_STRIDE +: 3] = lane_pos[i];
            status_word[IGB_STAT_DROP_LSB + i] = lane_drop[i];
            wcount_word[i * IGB_WCNT_STRIDE +: 16] = lane_wcnt[i];
        end
        status_word[IGB_STAT_MODE_LSB +: 2] = ctrl_mode_r;
        reg_rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                IGB_REG_CTRL:   reg_rdata_nxt = {30'h0000_0000, ctrl_mode_r};
                IGB_REG_STATUS: reg_rdata_nxt = status_word;
                IGB_REG_WCOUNT: reg_rdata_nxt = wcount_word;
                default:        reg_rdata_nxt = 32'h0000_0000;   // unmapped reads zero
            endcase
        end
    end

    // read data stands for the one cycle after the read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

endmodule : igb_gearbox

// ===== tb/igb_gearbox_props.sv
/*
 * igb_gearbox_props: port-level assertions of the input gearbox.
 * Assumes: bound to igb_gearbox; checked outputs all live on clk.
 */
`timescale 1ns/10ps
module igb_gearbox_props
    import igb_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  fast_edge_clk,
    input wire logic                  serial_in_a,
    input wire logic                  serial_in_c,
    input wire logic [IGB_LANES-1:0]  word_align_req,
    input wire logic [IGB_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata_r,
    input wire logic [IGB_WORD_W-1:0] par_word_r,
    input wire logic [IGB_LANES-1:0]  word_valid_r
);
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic [7:0] quiet_r;
    logic [7:0] quiet_nxt;
    logic       quiet;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // mirror of the set-up mode and time since it was last written
    always_comb begin
        mode_nxt  = mode_r;
        quiet_nxt = (quiet_r == 8'hFF) ? quiet_r : quiet_r + 8'h01;
        if (reg_wr && reg_addr == IGB_REG_CTRL) begin
            mode_nxt  = reg_wdata[1:0];
            quiet_nxt = 8'h00;
        end
    end

    // mirror registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r  <= IGB_CTRL_MODE_RST;
            quiet_r <= 8'h00;
        end else begin
            mode_r  <= mode_nxt;
            quiet_r <= quiet_nxt;
        end
    end

    // words in the 255 cycles after reset or a mode write are not judged by the quiet-gated checks
    assign quiet = (quiet_r == 8'hFF);

    property p_rst_clear;
        $fell(sys_rst) |-> par_word_r == 8'h00 && word_valid_r == 2'b00;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear");
    property p_word_hold; word_valid_r == 2'b00 |-> $stable(par_word_r); endproperty
    a_word_hold: assert property (p_word_hold) else $error("word moved without valid");
    property p_valid_gap; quiet && word_valid_r[1] |=> (!word_valid_r[1]) [*6]; endproperty
    a_valid_gap: assert property (p_valid_gap) else $error("words too close");
    property p_seven_top;
        quiet && mode_r == IGB_MODE_SEVEN && word_valid_r[1] |-> par_word_r[7] == 1'b0;
    endproperty
    a_seven_top: assert property (p_seven_top) else $error("bit 7 set in seven-bit mode");
    property p_dual_a;
        quiet && mode_r == IGB_MODE_DUAL && word_valid_r == 2'b10 |-> $stable(par_word_r[3:0]);
    endproperty
    a_dual_a: assert property (p_dual_a) else $error("lane a touched low half");
    property p_dual_c;
        quiet && mode_r == IGB_MODE_DUAL && word_valid_r == 2'b01 |-> $stable(par_word_r[7:4]);
    endproperty
    a_dual_c: assert property (p_dual_c) else $error("lane c touched high half");
    property p_ctrl_rb;
        reg_rd && reg_addr == IGB_REG_CTRL |=> reg_rdata_r == 32'(mode_r);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("mode readback wrong");
    property p_stat_mode;
        quiet && reg_rd && reg_addr == IGB_REG_STATUS |=> reg_rdata_r[9:8] == mode_r;
    endproperty
    a_stat_mode: assert property (p_stat_mode) else $error("status mode wrong");
endmodule : igb_gearbox_props

bind igb_gearbox igb_gearbox_props u_props (.clk(clk), .sys_rst(sys_rst),
    .fast_edge_clk(fast_edge_clk), .serial_in_a(serial_in_a), .serial_in_c(serial_in_c),
    .word_align_req(word_align_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .par_word_r(par_word_r),
    .word_valid_r(word_valid_r));

// ===== tb/igb_serial_src.sv
/*
 * igb_serial_src: far-side serial transmitter; makes the free-running edge
 * clock and repeats one pattern per lane, earliest bit the msb.
 * Assumes: patterns and width change only between tests.
 */
`timescale 1ns/10ps
module igb_serial_src
(
    input  wire logic [7:0] pat_a,
    input  wire logic [7:0] pat_c,
    input  wire logic [3:0] wid_a,
    output logic            fast_edge_clk,
    output logic            serial_in_a,
    output logic            serial_in_c
);
    int ia;
    int ic;

    // edge clock runs free; odd start offset keeps it unrelated to clk
    initial begin
        fast_edge_clk = 1'b0;
        #3.7;
        forever #16 fast_edge_clk = ~fast_edge_clk;
    end

    // one bit per edge, changed half way between edges
    initial begin
        ia = 0;
        ic = 0;
        serial_in_a = 1'b0;
        serial_in_c = 1'b0;
        forever begin
            @(fast_edge_clk);
            #8;
            if (ia >= int'(wid_a)) ia = 0;
            serial_in_a = pat_a[int'(wid_a) - 1 - ia];
            serial_in_c = pat_c[3 - ic];
            ia = (ia + 1) % int'(wid_a);
            ic = (ic + 1) % 4;
        end
    end
endmodule : igb_serial_src

// ===== tb/igb_gearbox_bench.sv
/*
 * igb_gearbox_bench: self-checking bench of the input gearbox, driving the
 * register port and alignment requests.
 * Assumes: the link comes from igb_serial_src with a 32 ns edge clock.
 */
`timescale 1ns/10ps
module igb_gearbox_bench
    import igb_pkg::*;
;
    logic         clk, sys_rst, reg_wr, reg_rd, fast_edge_clk, serial_in_a, serial_in_c;
    logic [1:0]   word_align_req, word_valid_r;
    logic [3:0]   reg_addr, wid_a;
    logic [31:0]  reg_wdata, reg_rdata_r, d;
    logic [7:0]   par_word_r, pat_a, w0, w1;
    int           mismatches, n_checks;
    igb_mode_type modes [3] = '{IGB_MODE_SEVEN, IGB_MODE_EIGHT, IGB_MODE_DUAL};
    logic [7:0]   pats  [3] = '{8'h4B, 8'hB1, 8'h01};
    logic [3:0]   wids  [3] = '{IGB_WIDTH_SEVEN, IGB_WIDTH_EIGHT, IGB_WIDTH_FOUR};

    igb_serial_src u_src (.pat_a(pat_a), .pat_c(8'h03), .wid_a(wid_a),
        .fast_edge_clk(fast_edge_clk), .serial_in_a(serial_in_a), .serial_in_c(serial_in_c));
    igb_gearbox u_dut (.clk(clk), .sys_rst(sys_rst), .fast_edge_clk(fast_edge_clk),
        .serial_in_a(serial_in_a), .serial_in_c(serial_in_c), .word_align_req(word_align_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .par_word_r(par_word_r), .word_valid_r(word_valid_r));

    // system clock, 5 ns
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // pattern p turned left by r inside a word of w bits
    function automatic logic [7:0] rot(input logic [7:0] p, input logic [3:0] w, input int r);
        logic [15:0] s;
        s = 16'(p) << r;
        return 8'((s | (s >> w)) & ((16'h1 << w) - 16'h1));
    endfunction : rot

    // got must be a turn of ref_w; with step1 exactly one bit either way
    task automatic chk_rot(input string nm, input logic [7:0] ref_w, input logic [7:0] got,
                           input logic [3:0] w, input logic step1);
        logic hit;
        hit = 1'b0;
        for (int r = 0; r < w; r++) begin
            if (got === rot(ref_w, w, r) && (!step1 || r == 1 || r == w - 1)) hit = 1'b1;
        end
        n_checks++;
        if (!hit) begin
            mismatches++;
            $display("BAD %s exp turn of %h got %h", nm, ref_w, got);
        end
    endtask : chk_rot

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata_r;
    endtask : rd

    task automatic pulse(input logic [1:0] m);
        @(posedge clk);
        word_align_req <= m;
        @(posedge clk);
        word_align_req <= 2'b00;
    endtask : pulse

    task automatic wait_word(input int lane, output logic [7:0] w);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (word_valid_r[lane] !== 1'b1 && n < 300);
        if (word_valid_r[lane] !== 1'b1) chk("word_valid", 32'h1, 32'h0);
        w = par_word_r;
    endtask : wait_word

    // watchdog against a hang
    initial begin
        #100000;
        mismatches++;
        $display("BAD watchdog exp done got hang");
        final_report();
    end

    // main sequence
    initial begin
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, word_align_req} = {1'b1, 40'h0};
        {pat_a, wid_a, mismatches, n_checks} = {8'hB1, IGB_WIDTH_EIGHT, 64'h0};
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(IGB_REG_CTRL, d);
        chk("ctrl_rst", 32'h1, d);
        rd(IGB_REG_STATUS, d);
        chk("status_rst", 32'h100, d);
        rd(IGB_REG_WCOUNT, d);
        chk("wcount_rst", 32'h0, d);
        rd(4'hC, d);
        chk("unmapped", 32'h0, d);
        wr(IGB_REG_CTRL, 32'h3);
        rd(IGB_REG_CTRL, d);
        chk("ctrl_spare", 32'h3, d);
        for (int i = 0; i < 3; i++) begin
            pat_a = pats[i];
            wid_a = wids[i];
            wr(IGB_REG_CTRL, 32'(modes[i]));
            repeat (5) wait_word(1, w0);
            if (i == 2) w0 = {4'h0, w0[7:4]};
            chk_rot("word_a", pats[i], w0, wids[i], 1'b0);
            pulse(2'b10);
            pulse(2'b10);
            repeat (3) wait_word(1, w1);
            if (i == 2) w1 = {4'h0, w1[7:4]};
            chk_rot("slip_a", w0, w1, wids[i], 1'b1);
            repeat (41) @(posedge clk);
            pulse(2'b01);
            rd(IGB_REG_STATUS, d);
            chk("status_slip", 32'h20010 | (32'(modes[i]) << 8) | 32'(i == 2), d);
            wr(IGB_REG_STATUS, 32'h20000);
            repeat (wids[i] - 4'h1) begin
                repeat (41) @(posedge clk);
                pulse(2'b10);
            end
            rd(IGB_REG_STATUS, d);
            chk("status_wrap", (32'(modes[i]) << 8) | 32'(i == 2), d);
        end
        wait_word(0, w1);
        chk_rot("word_c", 8'h03, {4'h0, w1[3:0]}, IGB_WIDTH_FOUR, 1'b0);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        #1;
        chk("word_in_rst", 32'h0, {22'h0, word_valid_r, par_word_r});
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(IGB_REG_STATUS, d);
        chk("status_rst2", 32'h100, d);
        final_report();
    end
endmodule : igb_gearbox_bench
